// file: core/dspm_pkg.sv
// Purpose: Shared constants and carrier types for the decoder/SPI pin mux.
// Assumes: Port C is 16 bits wide; only bits 0-3 and 8-10 are muxed here.
// Notes:   Shared pin order is phase A, phase B, index, home, then the
//          three current-status pins.
package dspm_pkg;

   // ******************************************************************
   // Sizes and pin order
   // ******************************************************************
   localparam int NUM_DEC = 4;
   localparam int NUM_CS = 3;
   localparam int NUM_SHARED = 7;
   localparam int NUM_PWM = 6;
   localparam int PORTC_W = 16;

   localparam int PIN_PHASE_A = 0;
   localparam int PIN_PHASE_B = 1;
   localparam int PIN_INDEX = 2;
   localparam int PIN_HOME = 3;
   localparam int PIN_CS0 = 4;

   // Port C bit that owns each shared pin, indexed by shared pin number
   localparam logic [NUM_SHARED-1:0][3:0] SHARED_PC_BIT =
      {4'ha, 4'h9, 4'h8, 4'h3, 4'h2, 4'h1, 4'h0};

   // ******************************************************************
   // Reset values
   // ******************************************************************
   localparam logic [PORTC_W-1:0] PULLUP_RST = 16'hffff;
   localparam logic [PORTC_W-1:0] GPIO_MODE_RST = 16'h0000;
   localparam logic [PORTC_W-1:0] DIR_RST = 16'h0000;
   localparam logic [PORTC_W-1:0] DOUT_RST = 16'h0000;
   localparam logic [NUM_DEC-1:0] SPI_SEL_RST = 4'h0;
   localparam logic MASTER_RST = 1'b0;

   // Levels the SPI core sees while its pins are not routed
   localparam logic SPI_IDLE_DATA = 1'b0;
   localparam logic SPI_IDLE_SS_N = 1'b1;

   // ******************************************************************
   // Carrier types
   // ******************************************************************
   typedef struct packed {
      logic gpioMode;
      logic gpioDir;
      logic gpioOut;
      logic pullEn;
   } dspm_pin_cfg_t;

   typedef struct packed {
      logic out;
      logic oe;
      logic pullEn;
   } dspm_pad_t;

   localparam dspm_pad_t PAD_RST = '{out: 1'b0, oe: 1'b0, pullEn: 1'b1};

endpackage : dspm_pkg

// file: core/dspm_pin_cell.sv
// Purpose: One shared pad: picks GPIO or peripheral drive, registers it.
// Assumes: Configuration arrives already registered from the mux top.
// Notes:   Output enable is high while the device drives the pad.
module dspm_pin_cell (
   input wire logic ref_clk,
   input wire logic rst,
   input dspm_pkg::dspm_pin_cfg_t cfg,
   input wire logic altOut,
   input wire logic altOe,
   input wire logic padIn,
   output dspm_pkg::dspm_pad_t pad,
   output logic gpioIn
);
   import dspm_pkg::*;

   dspm_pad_t pad_d;
   dspm_pad_t pad_q;
   logic gpioIn_q;

   // GPIO owns the pad when selected, otherwise the peripheral does
   always_comb begin
      pad_d.pullEn = cfg.pullEn;
      if (cfg.gpioMode) begin
         pad_d.out = cfg.gpioOut;
         pad_d.oe = cfg.gpioDir;
      end else begin
         pad_d.out = altOut;
         pad_d.oe = altOe;
      end
   end

   // Pad drive register; reset floats the pad with pull-up on
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pad_q <= PAD_RST;
      end else begin
         pad_q <= pad_d;
      end
   end

   // GPIO read-back; reads zero while a peripheral owns the pad
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         gpioIn_q <= 1'b0;
      end else begin
         gpioIn_q <= cfg.gpioMode & padIn;
      end
   end

   assign pad = pad_q;
   assign gpioIn = gpioIn_q;

endmodule : dspm_pin_cell

// file: core/dspm_pin_mux.sv
// Purpose: Pin mux for decoder phase A/B, index, home, current status
//          and the six PWM A outputs.
// Assumes: All pad inputs are synchronous to ref_clk.
// Notes:   Peripheral paths add one register stage, port C config two; SPI timing is kept since
//          clock and data pass through equal delay.
// Notes on behaviour
// - Phase-B select routes phase-B pad to SPI master-out data.
// - Index select routes index pad to SPI master-in data.
// - Home select routes home pad to SPI slave-select input.
// - After reset the four pins serve the decoder and timer B, not SPI/GPIO.
// - Clearing port C pull-up bits 1-3 drops phase-B/index/home pull-ups.
// - Each pin in GPIO mode is individually input or output.
// - Master drives master-out data half a clock before slave samples.
// - Unselected slave floats its master-in line.
// - Slave presents output data half a clock before master samples.
// - Slave select flags contention as master, selects device as slave.
// - Current-status inputs feed the PWM A pulse width correction.
// - At reset current-status pins serve current status, not GPIO.
// - Clearing the pull-up bit drops the current-status pin pull-up.
// - Six PWM A outputs stay tri-stated during reset.
// - Phase-A select routes phase-A pad to the SPI serial clock.
module dspm_pin_mux (
   input wire logic ref_clk,
   input wire logic rst,
   // Software configuration
   input wire logic [dspm_pkg::NUM_DEC-1:0] spiSelect,
   input wire logic spiMasterMode,
   input wire logic [dspm_pkg::PORTC_W-1:0] portCGpioMode,
   input wire logic [dspm_pkg::PORTC_W-1:0] portCDir,
   input wire logic [dspm_pkg::PORTC_W-1:0] portCDataOut,
   input wire logic [dspm_pkg::PORTC_W-1:0] portCPullupEnable,
   output logic [dspm_pkg::PORTC_W-1:0] portCDataIn,
   // Shared pads
   input wire logic [dspm_pkg::NUM_SHARED-1:0] padIn,
   output dspm_pkg::dspm_pad_t [dspm_pkg::NUM_SHARED-1:0] sharedPad,
   // Timer B channels 0-3
   input wire logic [dspm_pkg::NUM_DEC-1:0] timerBOut,
   input wire logic [dspm_pkg::NUM_DEC-1:0] timerBOe,
   output logic [dspm_pkg::NUM_DEC-1:0] timerBIn,
   // Decoder inputs
   output logic decoderPhaseAIn,
   output logic decoderPhaseBIn,
   output logic decoderIndexIn,
   output logic decoderHomeIn,
   // SPI B core side
   input wire logic spiBClkOut,
   input wire logic spiBMasterOut,
   input wire logic spiBMisoOut,
   output logic spiBClkIn,
   output logic spiBMasterOutIn,
   output logic spiBMasterIn,
   output logic spiBSlaveSelectN,
   output logic spiBContention,
   // PWM A
   input wire logic [dspm_pkg::NUM_PWM-1:0] pwmADrive,
   input wire logic pwmAEnable,
   output logic [dspm_pkg::NUM_PWM-1:0] pwmAOut,
   output logic [dspm_pkg::NUM_PWM-1:0] pwmAOe,
   output logic [dspm_pkg::NUM_CS-1:0] pwmACurrentStatus
);
   import dspm_pkg::*;

   // ******************************************************************
   // Configuration registers
   // ******************************************************************
   logic [NUM_DEC-1:0] spiSel_q;
   logic master_q;
   logic [PORTC_W-1:0] gpioMode_q;
   logic [PORTC_W-1:0] dir_q;
   logic [PORTC_W-1:0] dout_q;
   logic [PORTC_W-1:0] pull_q;

   // reset defaults: peripheral functions, SPI off, pull-ups on
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         spiSel_q <= SPI_SEL_RST;
         master_q <= MASTER_RST;
         gpioMode_q <= GPIO_MODE_RST;
         dir_q <= DIR_RST;
         dout_q <= DOUT_RST;
         pull_q <= PULLUP_RST;
      end else begin
         spiSel_q <= spiSelect;
         master_q <= spiMasterMode;
         gpioMode_q <= portCGpioMode;
         dir_q <= portCDir;
         dout_q <= portCDataOut;
         pull_q <= portCPullupEnable;
      end
   end

   // ******************************************************************
   // Peripheral drive per shared pin
   // ******************************************************************
   logic [NUM_SHARED-1:0] altOut;
   logic [NUM_SHARED-1:0] altOe;
   logic [NUM_DEC-1:0] spiRouted;
   logic ssN;
   logic [NUM_SHARED-1:0] gpioRaw;

   // A pin routes to SPI only when GPIO does not own it
   always_comb begin
      for (int i = 0; i < NUM_DEC; i++) begin
         spiRouted[i] = spiSel_q[i] &
            ~gpioMode_q[SHARED_PC_BIT[i]];
      end
   end

   // slave select pad; idle high when home is not routed
   assign ssN = spiRouted[PIN_HOME] ? padIn[PIN_HOME] : SPI_IDLE_SS_N;

   // Decoder pins fall back to the timer channel when SPI is off
   always_comb begin
      altOut = '0;
      altOe = '0;
      for (int i = 0; i < NUM_DEC; i++) begin
         altOut[i] = timerBOut[i];
         altOe[i] = timerBOe[i];
      end
      if (spiRouted[PIN_PHASE_A]) begin
         altOut[PIN_PHASE_A] = spiBClkOut;
         altOe[PIN_PHASE_A] = master_q;
      end
      if (spiRouted[PIN_PHASE_B]) begin
         altOut[PIN_PHASE_B] = spiBMasterOut;
         altOe[PIN_PHASE_B] = master_q;
      end
      if (spiRouted[PIN_INDEX]) begin
         altOut[PIN_INDEX] = spiBMisoOut;
         altOe[PIN_INDEX] = ~master_q & ~ssN;
      end
      if (spiRouted[PIN_HOME]) begin
         altOut[PIN_HOME] = 1'b0;
         altOe[PIN_HOME] = 1'b0;
      end
   end

   // ******************************************************************
   // Pad cells
   // ******************************************************************
   genvar g;
   generate
      for (g = 0; g < NUM_SHARED; g++) begin : gPin
         dspm_pin_cfg_t cfg;
         assign cfg.gpioMode = gpioMode_q[SHARED_PC_BIT[g]];
         assign cfg.gpioDir = dir_q[SHARED_PC_BIT[g]];
         assign cfg.gpioOut = dout_q[SHARED_PC_BIT[g]];
         assign cfg.pullEn = pull_q[SHARED_PC_BIT[g]];
         dspm_pin_cell uCell (
            .ref_clk(ref_clk),
            .rst(rst),
            .cfg(cfg),
            .altOut(altOut[g]),
            .altOe(altOe[g]),
            .padIn(padIn[g]),
            .pad(sharedPad[g]),
            .gpioIn(gpioRaw[g])
         );
         assign portCDataIn[SHARED_PC_BIT[g]] = gpioRaw[g];
         chk_gpio_dir: assert property (@(posedge ref_clk) disable iff (rst)
            gpioMode_q[SHARED_PC_BIT[g]] |=>
            sharedPad[g].oe == $past(dir_q[SHARED_PC_BIT[g]]))
            else $error("GPIO pad enable does not follow direction");
         chk_pull_follow: assert property (@(posedge ref_clk)
            disable iff (rst)
            1'b1 |=> sharedPad[g].pullEn == $past(pull_q[SHARED_PC_BIT[g]]))
            else $error("Pad pull-up does not follow enable bit");
      end
   endgenerate

   // Port C bits not muxed here read as zero
   assign portCDataIn[7:4] = 4'h0;
   assign portCDataIn[15:11] = 5'h00;

   // ******************************************************************
   // Inputs to the cores
   // ******************************************************************
   logic [NUM_DEC-1:0] decPeriph;
   assign decPeriph = ~spiRouted & ~{gpioMode_q[SHARED_PC_BIT[3]],
      gpioMode_q[SHARED_PC_BIT[2]], gpioMode_q[SHARED_PC_BIT[1]],
      gpioMode_q[SHARED_PC_BIT[0]]};

   // decoder and timer see pads unless SPI or GPIO own them
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         decoderPhaseAIn <= 1'b0;
         decoderPhaseBIn <= 1'b0;
         decoderIndexIn <= 1'b0;
         decoderHomeIn <= 1'b0;
         timerBIn <= '0;
      end else begin
         decoderPhaseAIn <= decPeriph[PIN_PHASE_A] & padIn[PIN_PHASE_A];
         decoderPhaseBIn <= decPeriph[PIN_PHASE_B] & padIn[PIN_PHASE_B];
         decoderIndexIn <= decPeriph[PIN_INDEX] & padIn[PIN_INDEX];
         decoderHomeIn <= decPeriph[PIN_HOME] & padIn[PIN_HOME];
         timerBIn <= decPeriph & padIn[NUM_DEC-1:0];
      end
   end

   // SPI inputs idle while their pins are not routed
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         spiBClkIn <= SPI_IDLE_DATA;
         spiBMasterOutIn <= SPI_IDLE_DATA;
         spiBMasterIn <= SPI_IDLE_DATA;
         spiBSlaveSelectN <= SPI_IDLE_SS_N;
      end else begin
         spiBClkIn <= spiRouted[PIN_PHASE_A] ? padIn[PIN_PHASE_A]
            : SPI_IDLE_DATA;
         spiBMasterOutIn <= spiRouted[PIN_PHASE_B] ? padIn[PIN_PHASE_B]
            : SPI_IDLE_DATA;
         spiBMasterIn <= spiRouted[PIN_INDEX] ? padIn[PIN_INDEX]
            : SPI_IDLE_DATA;
         spiBSlaveSelectN <= ssN;
      end
   end

   // another master pulling select low while we are master
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         spiBContention <= 1'b0;
      end else begin
         spiBContention <= master_q & ~ssN;
      end
   end

   // current status reaches PWM unless GPIO takes the pin
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pwmACurrentStatus <= '0;
      end else begin
         for (int i = 0; i < NUM_CS; i++) begin
            pwmACurrentStatus[i] <= ~gpioMode_q[SHARED_PC_BIT[PIN_CS0+i]]
               & padIn[PIN_CS0+i];
         end
      end
   end

   // ******************************************************************
   // PWM A outputs
   // ******************************************************************
   // outputs float under reset and until PWM enables them
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pwmAOut <= '0;
         pwmAOe <= '0;
      end else begin
         pwmAOut <= pwmADrive;
         pwmAOe <= {NUM_PWM{pwmAEnable}};
      end
   end

   // ******************************************************************
   // Checks
   // ******************************************************************
   sequence sMosiRouted;
      spiRouted[PIN_PHASE_B] && master_q;
   endsequence

   sequence sSlaveSelected;
      spiRouted[PIN_INDEX] && !master_q && !ssN;
   endsequence

   chk_mosi_route: assert property (@(posedge ref_clk) disable iff (rst)
      sMosiRouted |=> sharedPad[PIN_PHASE_B].oe &&
      sharedPad[PIN_PHASE_B].out == $past(spiBMasterOut))
      else $error("Master-out data not on phase-B pad");

   chk_miso_drive: assert property (@(posedge ref_clk) disable iff (rst)
      sSlaveSelected |=> sharedPad[PIN_INDEX].oe &&
      sharedPad[PIN_INDEX].out == $past(spiBMisoOut))
      else $error("Selected slave data not on index pad");

   chk_miso_float: assert property (@(posedge ref_clk) disable iff (rst)
      spiRouted[PIN_INDEX] && !master_q && ssN
      |=> !sharedPad[PIN_INDEX].oe)
      else $error("Unselected slave drives index pad");

   chk_ss_route: assert property (@(posedge ref_clk) disable iff (rst)
      spiRouted[PIN_HOME] |=> spiBSlaveSelectN == $past(padIn[PIN_HOME]))
      else $error("Home pad not routed to slave select");

   chk_ss_idle: assert property (@(posedge ref_clk) disable iff (rst)
      !spiSel_q[PIN_HOME] |=> spiBSlaveSelectN == SPI_IDLE_SS_N)
      else $error("Slave select not idle while unrouted");

   chk_contention_flag: assert property (@(posedge ref_clk)
      disable iff (rst)
      master_q && spiRouted[PIN_HOME] && !padIn[PIN_HOME]
      |=> spiBContention)
      else $error("Master contention not flagged");

   chk_status_feed: assert property (@(posedge ref_clk) disable iff (rst)
      !gpioMode_q[SHARED_PC_BIT[PIN_CS0]]
      |=> pwmACurrentStatus[0] == $past(padIn[PIN_CS0]))
      else $error("Current status not fed to PWM");

   chk_reset_float: assert property (@(posedge ref_clk) disable iff (1'b0)
      rst ##1 rst |-> pwmAOe == '0 && spiSel_q == '0 &&
      gpioMode_q == GPIO_MODE_RST)
      else $error("Pins not in reset defaults during reset");

endmodule : dspm_pin_mux

// file: test/dspm_far_side.sv
// Purpose: Far side of the shared pads: encoder, SPI peer, wire level.
// Assumes: Bench chooses which pins the outside world drives.
// Notes:   A released line without pull-up flips every cycle.
module dspm_far_side (
   input wire logic ref_clk,
   input dspm_pkg::dspm_pad_t [dspm_pkg::NUM_SHARED-1:0] sharedPad,
   input wire logic [dspm_pkg::NUM_SHARED-1:0] extVal,
   input wire logic [dspm_pkg::NUM_SHARED-1:0] extOe,
   output logic [dspm_pkg::NUM_SHARED-1:0] padIn
);
   timeunit 1ns;
   timeprecision 100ps;
   import dspm_pkg::*;

   logic [NUM_SHARED-1:0] lastLvl_q;

   // Remember the wire so a floating line cannot look stable
   always_ff @(posedge ref_clk) begin
      lastLvl_q <= padIn;
   end

   // Wire level: device first, then peer, then pull-up, else drift
   // peer holds data, releases line
   always_comb begin
      for (int i = 0; i < NUM_SHARED; i++) begin
         if (sharedPad[i].oe) begin
            padIn[i] = sharedPad[i].out;
         end else if (extOe[i]) begin
            padIn[i] = extVal[i];
         end else if (sharedPad[i].pullEn) begin
            padIn[i] = 1'b1;
         end else begin
            padIn[i] = ~lastLvl_q[i];
         end
      end
   end
endmodule : dspm_far_side

// file: test/dspm_pin_mux_tb.sv
// Purpose: Self-checking bench for the decoder/SPI pin mux.
// Assumes: Config reaches pads two edges after a port change.
// Notes:   Checks wait three or four edges after config changes so registered data paths settle too, two after data-only changes.
module dspm_pin_mux_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import dspm_pkg::*;

   logic ref_clk, rst, spiMasterMode, pwmAEnable;
   logic spiBClkOut, spiBMasterOut, spiBMisoOut;
   logic [3:0] spiSelect, timerBOut, timerBOe, timerBIn;
   logic [15:0] portCGpioMode, portCDir, portCDataOut;
   logic [15:0] portCPullupEnable, portCDataIn;
   logic [6:0] padIn, extVal, extOe;
   dspm_pad_t [6:0] sharedPad;
   logic decoderPhaseAIn, decoderPhaseBIn, decoderIndexIn, decoderHomeIn;
   logic spiBClkIn, spiBMasterOutIn, spiBMasterIn;
   logic spiBSlaveSelectN, spiBContention;
   logic [5:0] pwmADrive, pwmAOut, pwmAOe;
   logic [2:0] pwmACurrentStatus;
   int failures = 0;
   int total_checks = 0;
   int cycles = 0;

   dspm_pin_mux u_dspm_pin_mux (.ref_clk(ref_clk), .rst(rst),
      .spiSelect(spiSelect), .spiMasterMode(spiMasterMode),
      .portCGpioMode(portCGpioMode), .portCDir(portCDir),
      .portCDataOut(portCDataOut), .portCPullupEnable(portCPullupEnable),
      .portCDataIn(portCDataIn), .padIn(padIn), .sharedPad(sharedPad),
      .timerBOut(timerBOut), .timerBOe(timerBOe), .timerBIn(timerBIn),
      .decoderPhaseAIn(decoderPhaseAIn), .decoderPhaseBIn(decoderPhaseBIn),
      .decoderIndexIn(decoderIndexIn), .decoderHomeIn(decoderHomeIn),
      .spiBClkOut(spiBClkOut), .spiBMasterOut(spiBMasterOut),
      .spiBMisoOut(spiBMisoOut), .spiBClkIn(spiBClkIn),
      .spiBMasterOutIn(spiBMasterOutIn), .spiBMasterIn(spiBMasterIn),
      .spiBSlaveSelectN(spiBSlaveSelectN), .spiBContention(spiBContention),
      .pwmADrive(pwmADrive), .pwmAEnable(pwmAEnable), .pwmAOut(pwmAOut),
      .pwmAOe(pwmAOe), .pwmACurrentStatus(pwmACurrentStatus));

   dspm_far_side u_dspm_far_side (.ref_clk(ref_clk),
      .sharedPad(sharedPad), .extVal(extVal), .extOe(extOe),
      .padIn(padIn));

   // ****************************************************************
   // Clock, watchdog and helpers
   // ****************************************************************
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   // Whole run is well under 200 cycles; a hang counts as a mismatch
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 2000) begin
         failures++;
         summarize();
      end
   end

   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : step

   task automatic chkB(input string nm, input logic e, input logic g);
      total_checks++;
      if (g !== e) begin
         failures++;
         $display("BAD %s exp %b got %b", nm, e, g);
      end
   endtask : chkB

   task automatic chkW(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         failures++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask : chkW

   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : summarize

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic testReset();
      step(3);
      chkW("pwmAOe", 16'h0000, 16'(pwmAOe));
      for (int i = 0; i < 7; i++) begin
         chkB("padOe", 1'b0, sharedPad[i].oe);
      end
      rst = 1'b0;
      pwmAEnable = 1'b0;
      step(3);
      chkB("phaseA", 1'b1, decoderPhaseAIn);
      chkB("phaseB", 1'b1, decoderPhaseBIn);
      chkB("index", 1'b0, decoderIndexIn);
      chkB("home", 1'b1, decoderHomeIn);
      chkW("timerIn", 16'h000b, 16'(timerBIn));
      chkB("pad1Oe", 1'b1, sharedPad[1].oe);
      chkB("spiMosi", 1'b0, spiBMasterOutIn);
      chkB("spiMiso", 1'b0, spiBMasterIn);
      chkB("spiSsN", 1'b1, spiBSlaveSelectN);
      chkW("gpioIn", 16'h0000, portCDataIn);
      chkW("curStat", 16'h0005, 16'(pwmACurrentStatus));
      $display("done reset");
   endtask : testReset

   task automatic testSpiMaster();
      spiSelect = 4'hf;
      spiMasterMode = 1'b1;
      timerBOe = 4'h0;
      spiBClkOut = 1'b1;
      extOe = 7'h7c;
      extVal = 7'h74;
      step(3);
      chkB("sclkOe", 1'b1, sharedPad[0].oe);
      chkB("sclkOut", 1'b1, sharedPad[0].out);
      chkB("mosiOe", 1'b1, sharedPad[1].oe);
      chkB("mosiOut", 1'b0, sharedPad[1].out);
      chkB("misoOe", 1'b0, sharedPad[2].oe);
      chkB("spiMiso", 1'b1, spiBMasterIn);
      chkB("index", 1'b0, decoderIndexIn);
      chkB("phaseA", 1'b0, decoderPhaseAIn);
      chkB("spiSsN", 1'b0, spiBSlaveSelectN);
      chkB("contend", 1'b1, spiBContention);
      extVal = 7'h7c;
      spiBMasterOut = 1'b1;
      step(2);
      chkB("mosiOut", 1'b1, sharedPad[1].out);
      chkB("contend", 1'b0, spiBContention);
      $display("done spi master");
   endtask : testSpiMaster

   task automatic testSpiSlave();
      spiMasterMode = 1'b0;
      spiBMisoOut = 1'b1;
      extOe = 7'h7b;
      extVal = 7'h0b;
      step(3);
      chkB("spiClk", 1'b1, spiBClkIn);
      chkB("spiMosi", 1'b1, spiBMasterOutIn);
      chkB("sclkOe", 1'b0, sharedPad[0].oe);
      chkB("misoOe", 1'b0, sharedPad[2].oe);
      chkB("spiSsN", 1'b1, spiBSlaveSelectN);
      extVal = 7'h03;
      step(2);
      chkB("spiSsN", 1'b0, spiBSlaveSelectN);
      chkB("misoOe", 1'b1, sharedPad[2].oe);
      chkB("misoOut", 1'b1, sharedPad[2].out);
      chkB("contend", 1'b0, spiBContention);
      $display("done spi slave");
   endtask : testSpiSlave

   task automatic testGpio();
      logic [3:0] b;
      spiMasterMode = 1'b1;
      portCGpioMode = 16'h070f;
      portCDir = 16'h0505;
      portCDataOut = 16'h0401;
      extOe = 7'h2a;
      extVal = 7'h22;
      step(4);
      for (int i = 0; i < 7; i++) begin
         b = SHARED_PC_BIT[i];
         chkB("gpioOe", portCDir[b], sharedPad[i].oe);
         if (portCDir[b]) begin
            chkB("gpioOut", portCDataOut[b], sharedPad[i].out);
         end
      end
      chkW("gpioIn", 16'h0603, portCDataIn);
      chkB("phaseB", 1'b0, decoderPhaseBIn);
      chkB("spiMiso", 1'b0, spiBMasterIn);
      chkW("curStat", 16'h0000, 16'(pwmACurrentStatus));
      portCGpioMode = 16'h0000;
      spiSelect = 4'h0;
      $display("done gpio");
   endtask : testGpio

   task automatic testPullup();
      logic [15:0] v;
      for (int k = 0; k < 2; k++) begin
         v = (k == 0) ? 16'hf8f1 : 16'h070e;
         portCPullupEnable = v;
         step(3);
         for (int i = 0; i < 4; i++) begin
            chkB("pullEn", v[SHARED_PC_BIT[i]], sharedPad[i].pullEn);
         end
         // Current-status pads follow port C bits 8-10
         for (int i = 4; i < 7; i++) begin
            chkB("pullEn", v[SHARED_PC_BIT[i]], sharedPad[i].pullEn);
         end
      end
      portCPullupEnable = 16'hffff;
      $display("done pullup");
   endtask : testPullup

   task automatic testPwm();
      pwmAEnable = 1'b1;
      pwmADrive = 6'h15;
      extOe = 7'h70;
      extVal = 7'h50;
      step(3);
      chkW("pwmAOe", 16'h003f, 16'(pwmAOe));
      chkW("pwmAOut", 16'h0015, 16'(pwmAOut));
      chkW("curStat", 16'h0005, 16'(pwmACurrentStatus));
      pwmADrive = 6'h2a;
      extVal = 7'h20;
      step(2);
      chkW("pwmAOut", 16'h002a, 16'(pwmAOut));
      chkW("curStat", 16'h0002, 16'(pwmACurrentStatus));
      rst = 1'b1;
      step(2);
      chkW("pwmAOe", 16'h0000, 16'(pwmAOe));
      rst = 1'b0;
      pwmAEnable = 1'b0;
      step(3);
      $display("done pwm");
   endtask : testPwm

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      rst = 1'b1;
      spiSelect = 4'h0;
      spiMasterMode = 1'b0;
      portCGpioMode = 16'h0000;
      portCDir = 16'h0000;
      portCDataOut = 16'h0000;
      portCPullupEnable = 16'hffff;
      timerBOut = 4'h2;
      timerBOe = 4'h2;
      spiBClkOut = 1'b0;
      spiBMasterOut = 1'b0;
      spiBMisoOut = 1'b0;
      pwmADrive = 6'h3f;
      pwmAEnable = 1'b1;
      extVal = 7'h5b;
      extOe = 7'h7d;
      testReset();
      testSpiMaster();
      testSpiSlave();
      testGpio();
      testPullup();
      testPwm();
      summarize();
   end
endmodule : dspm_pin_mux_tb
